/* pkg/pwrseq_pkg.sv */
// Constants and types for the channel power-on sequencer
package pwrseq_pkg;
	// Register indices; byte address is four times the index
	localparam logic [15:0] STATUS_IDX  = 16'hFE78;
	localparam logic [15:0] CHA_SET_IDX = 16'hFE79;
	localparam logic [15:0] CHB_SET_IDX = 16'hFE7A;
	localparam logic [15:0] CHC_SEQ_IDX = 16'hFE7B;
	localparam logic [7:0]  REG_RESET   = 8'h00;

	// Channel A/B setting fields
	localparam int POL_BIT = 7;
	localparam int SW_BIT  = 6;
	localparam int SEL_HI  = 5;
	localparam int SEL_LO  = 4;
	localparam int ON_HI   = 3;
	localparam int ON_LO   = 2;
	localparam int OFF_HI  = 1;
	localparam int OFF_LO  = 0;

	// Channel C sequencing fields
	localparam int ADD_C_BIT    = 7;
	localparam int ADD_B_BIT    = 6;
	localparam int ADD_A_BIT    = 5;
	localparam int C_FOLLOW_BIT = 4;

	// On-request source selection
	localparam logic [1:0] SEL_ALWAYS = 2'h0;
	localparam logic [1:0] SEL_PIN    = 2'h1;
	localparam logic [1:0] SEL_SW     = 2'h2;
	localparam logic [1:0] SEL_BOTH   = 2'h3;

	// Delay table in milliseconds
	localparam int DLY_W = 10;
	localparam logic [DLY_W-1:0] DLY0_MS = 10'h000;
	localparam logic [DLY_W-1:0] DLY1_MS = 10'h032;
	localparam logic [DLY_W-1:0] DLY2_MS = 10'h0FA;
	localparam logic [DLY_W-1:0] DLY3_MS = 10'h3E8;

	localparam int CLK_HZ_DEFAULT = 25_000_000;
	localparam int MS_PER_S       = 1000;

	typedef enum logic [2:0] {
		ST_OFF, ST_ON_WAIT, ST_ON, ST_OFF_WAIT, ST_FAULT, ST_EXTRA_WAIT
	} seq_state_t;
endpackage

/* hw/chan_power_seq.sv */
// Channel A/B/C on/off sequencer with Wishbone register access
// Overview of operation
// [RL1] Bit 7 set adds the C turn-on delay after fault re-enable.
// [RL2] Bit 6 set adds the B turn-on delay after fault re-enable.
// [RL3] Bit 5 set adds the A turn-on delay after fault re-enable.
// [RL4] Bit 4 makes C always requested or follow A/B requests.
// [RL5] C soft start waits 0, 50, 250 or 1000 ms per bits 3:2.
// [RL6] C turns off 0, 50, 250 or 1000 ms after request drops.
// [RL7] Extra delay applies only between fault clear and soft start.
// [RL8] A request: always, pin only, software only, or pin and software.
// [RL9] Bit 4 zero means C always on; one means A or B.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module chan_power_seq
	import pwrseq_pkg::*;
#(
	parameter int CLK_HZ    = CLK_HZ_DEFAULT,
	parameter int MS_CYCLES = CLK_HZ / MS_PER_S
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [17:0] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic        chan_a_on_request_i,
	input  wire logic        chan_b_on_request_i,
	input  wire logic        fault_a_i,
	input  wire logic        fault_b_i,
	input  wire logic        fault_c_i,
	input  wire logic        reenable_a_i,
	input  wire logic        reenable_b_i,
	input  wire logic        reenable_c_i,
	output logic             chan_a_enable_o,
	output logic             chan_b_enable_o,
	output logic             chan_c_enable_o,
	output logic             soft_start_a_o,
	output logic             soft_start_b_o,
	output logic             soft_start_c_o
);
	localparam int MS_W = $clog2(MS_CYCLES + 1);

	if (MS_CYCLES < 2) begin : g_bad_ms
		$error("MS_CYCLES must be at least 2");
	end

	function automatic logic [DLY_W-1:0] delay_ms(input logic [1:0] code);
		case (code)
			2'h0:    delay_ms = DLY0_MS;
			2'h1:    delay_ms = DLY1_MS;
			2'h2:    delay_ms = DLY2_MS;
			default: delay_ms = DLY3_MS;
		endcase
	endfunction

	function automatic logic pick_request(input logic [7:0] set,
		input logic pin);
		logic hw;
		hw = pin ^ set[POL_BIT];
		case (set[SEL_HI:SEL_LO])
			SEL_ALWAYS: pick_request = 1'b1;
			SEL_PIN:    pick_request = hw;
			SEL_SW:     pick_request = set[SW_BIT];
			default:    pick_request = hw & set[SW_BIT];
		endcase
	endfunction

	// Pin synchronisers
	logic [1:0] pin_a_sync;
	logic [1:0] pin_b_sync;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_a_sync <= 2'h0;
			pin_b_sync <= 2'h0;
		end else begin
			pin_a_sync <= {pin_a_sync[0], chan_a_on_request_i};
			pin_b_sync <= {pin_b_sync[0], chan_b_on_request_i};
		end
	end

	// Register file and bus slave
	logic [7:0]  set_a, set_b, seq_c;
	logic [7:0]  next_set_a, next_set_b, next_seq_c;
	logic [31:0] next_dat;
	logic        next_ack;
	logic [2:0]  enable, start;
	logic [2:0]  req;
	logic [15:0] idx;
	logic        wr;

	assign idx = adr_i[17:2];

	always_comb begin
		wr = cyc_i & stb_i & ~ack_o & we_i & sel_i[0];
		next_ack = cyc_i & stb_i & ~ack_o;
		next_set_a = set_a;
		next_set_b = set_b;
		next_seq_c = seq_c;
		if (wr && idx == CHA_SET_IDX)
			next_set_a = dat_i[7:0];
		if (wr && idx == CHB_SET_IDX)
			next_set_b = dat_i[7:0];
		if (wr && idx == CHC_SEQ_IDX)
			next_seq_c = dat_i[7:0];
		next_dat = 32'h0000_0000;
		// Unmapped addresses read zero and ignore writes
		case (idx)
			STATUS_IDX:  next_dat = {24'h00_0000, 2'h0, req, enable};
			CHA_SET_IDX: next_dat = {24'h00_0000, set_a};
			CHB_SET_IDX: next_dat = {24'h00_0000, set_b};
			CHC_SEQ_IDX: next_dat = {24'h00_0000, seq_c};
			default:     next_dat = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			set_a <= REG_RESET;
			set_b <= REG_RESET;
			seq_c <= REG_RESET;
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			set_a <= next_set_a;
			set_b <= next_set_b;
			seq_c <= next_seq_c;
			ack_o <= next_ack;
			dat_o <= next_dat;
		end
	end

	// Millisecond time base; first tick after a request may come early,
	// so every delay is accurate to within one millisecond
	logic [MS_W-1:0] ms_cnt, next_ms_cnt;
	logic            tick, next_tick;
	always_comb begin
		next_tick = (ms_cnt == MS_W'(MS_CYCLES - 1));
		next_ms_cnt = next_tick ? '0 : ms_cnt + 1'b1;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ms_cnt <= '0;
			tick <= 1'b0;
		end else begin
			ms_cnt <= next_ms_cnt;
			tick <= next_tick;
		end
	end

	// Per-channel sequencing, index 0..2 is A, B, C
	seq_state_t       state [3];
	seq_state_t       next_state [3];
	logic [DLY_W-1:0] cnt [3];
	logic [DLY_W-1:0] next_cnt [3];
	logic [DLY_W-1:0] on_ms [3];
	logic [DLY_W-1:0] off_ms [3];
	logic [2:0]       fault, reen, add, next_enable, next_start;

	always_comb begin
		fault = {fault_c_i, fault_b_i, fault_a_i};
		reen = {reenable_c_i, reenable_b_i, reenable_a_i};
		// [RL1] [RL2] [RL3] extra delay enables
		add = {seq_c[ADD_C_BIT], seq_c[ADD_B_BIT], seq_c[ADD_A_BIT]};
		// [RL8] request source select
		req[0] = pick_request(set_a, pin_a_sync[1]);
		req[1] = pick_request(set_b, pin_b_sync[1]);
		// [RL4] [RL9] C always on or follows A/B
		req[2] = seq_c[C_FOLLOW_BIT] ? (req[0] | req[1]) : 1'b1;
		on_ms[0] = delay_ms(set_a[ON_HI:ON_LO]);
		on_ms[1] = delay_ms(set_b[ON_HI:ON_LO]);
		on_ms[2] = delay_ms(seq_c[ON_HI:ON_LO]);
		off_ms[0] = delay_ms(set_a[OFF_HI:OFF_LO]);
		off_ms[1] = delay_ms(set_b[OFF_HI:OFF_LO]);
		off_ms[2] = delay_ms(seq_c[OFF_HI:OFF_LO]);
		for (int i = 0; i < 3; i++) begin
			next_state[i] = state[i];
			next_cnt[i] = cnt[i];
			next_start[i] = 1'b0;
			if (tick && cnt[i] != '0)
				next_cnt[i] = cnt[i] - 1'b1;
			unique case (state[i])
				ST_OFF:
					if (fault[i]) begin
						next_state[i] = ST_FAULT;
					end else if (req[i]) begin
						// [RL5] turn-on delay before soft start
						next_cnt[i] = on_ms[i];
						next_state[i] = ST_ON_WAIT;
						if (on_ms[i] == DLY0_MS) begin
							next_state[i] = ST_ON;
							next_start[i] = 1'b1;
						end
					end
				ST_ON_WAIT, ST_EXTRA_WAIT:
					if (fault[i]) begin
						next_state[i] = ST_FAULT;
					end else if (!req[i]) begin
						next_state[i] = ST_OFF;
					end else if (tick && cnt[i] == DLY_W'(1)) begin
						next_state[i] = ST_ON;
						next_start[i] = 1'b1;
					end
				ST_ON:
					if (fault[i]) begin
						next_state[i] = ST_FAULT;
					end else if (!req[i]) begin
						// [RL6] turn-off delay after request drops
						next_cnt[i] = off_ms[i];
						next_state[i] = (off_ms[i] == DLY0_MS) ?
							ST_OFF : ST_OFF_WAIT;
					end
				ST_OFF_WAIT:
					if (fault[i]) begin
						next_state[i] = ST_FAULT;
					end else if (req[i]) begin
						next_state[i] = ST_ON;
					end else if (tick && cnt[i] == DLY_W'(1)) begin
						next_state[i] = ST_OFF;
					end
				ST_FAULT:
					if (!fault[i] && reen[i]) begin
						// [RL7] extra wait only after a fault clears
						next_cnt[i] = on_ms[i];
						if (!req[i]) begin
							next_state[i] = ST_OFF;
						end else if (add[i] && on_ms[i] != DLY0_MS) begin
							next_state[i] = ST_EXTRA_WAIT;
						end else begin
							next_state[i] = ST_ON;
							next_start[i] = 1'b1;
						end
					end
			endcase
			next_enable[i] = (next_state[i] == ST_ON) ||
				(next_state[i] == ST_OFF_WAIT);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 3; i++) begin
				state[i] <= ST_OFF;
				cnt[i] <= '0;
			end
			enable <= 3'h0;
			start <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				state[i] <= next_state[i];
				cnt[i] <= next_cnt[i];
			end
			enable <= next_enable;
			start <= next_start;
		end
	end

	assign chan_a_enable_o = enable[0];
	assign chan_b_enable_o = enable[1];
	assign chan_c_enable_o = enable[2];
	assign soft_start_a_o = start[0];
	assign soft_start_b_o = start[1];
	assign soft_start_c_o = start[2];

	// Helper: milliseconds spent in the current wait state of channel C
	logic [DLY_W:0] c_wait_ms;
	always_ff @(posedge clk_i) begin
		if (rst_i || next_state[2] != state[2])
			c_wait_ms <= '0;
		else if (tick)
			c_wait_ms <= c_wait_ms + 1'b1;
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	c_source_a: assert property (req[2] == // [RL9]
		(seq_c[C_FOLLOW_BIT] ? (req[0] | req[1]) : 1'b1))
		else $error("channel C request source wrong");
	c_follow_a: assert property (seq_c[C_FOLLOW_BIT] && // [RL4]
		!req[0] && !req[1] |-> !req[2])
		else $error("channel C requested without A or B");
	c_on_delay_a: assert property (state[2] == ST_ON_WAIT && // [RL5]
		next_state[2] == ST_ON |-> c_wait_ms + 1'b1 == on_ms[2])
		else $error("channel C turn-on delay wrong");
	c_off_delay_a: assert property (state[2] == ST_OFF_WAIT && // [RL6]
		next_state[2] == ST_OFF |-> c_wait_ms + 1'b1 == off_ms[2])
		else $error("channel C turn-off delay wrong");
	c_extra_a: assert property (state[2] == ST_FAULT && reen[2] && // [RL1]
		!fault[2] && req[2] && !seq_c[ADD_C_BIT] |=> soft_start_c_o)
		else $error("channel C extra delay added while disabled");
	b_extra_a: assert property (state[1] == ST_FAULT && reen[1] && // [RL2]
		!fault[1] && req[1] && add[1] && on_ms[1] != DLY0_MS
		|=> !soft_start_b_o [*2])
		else $error("channel B extra delay skipped");
	a_extra_a: assert property (state[0] == ST_FAULT && reen[0] && // [RL3]
		!fault[0] && req[0] && !add[0] |=> chan_a_enable_o)
		else $error("channel A re-enable delayed");
	extra_origin_a: assert property ($rose(state[2] == ST_EXTRA_WAIT) // [RL7]
		|-> $past(state[2]) == ST_FAULT)
		else $error("extra delay entered outside fault recovery");
	a_select_a: assert property (set_a[SEL_HI:SEL_LO] == SEL_BOTH // [RL8]
		|-> req[0] == ((pin_a_sync[1] ^ set_a[POL_BIT]) & set_a[SW_BIT]))
		else $error("channel A request select wrong");

	c_extra_start_c: cover property (state[2] == ST_EXTRA_WAIT
		##1 soft_start_c_o);
	c_off_wait_c: cover property (state[2] == ST_OFF_WAIT
		##1 state[2] == ST_OFF);
	c_follow_c: cover property (seq_c[C_FOLLOW_BIT] && req[0]
		##1 chan_c_enable_o);
endmodule
`default_nettype wire

/* tb/chan_power_seq_tb.sv */
// Self-checking bench for the channel power sequencer
`timescale 1ns/100ps
`default_nettype none
module chan_power_seq_tb;
	import pwrseq_pkg::*;
	// Short millisecond tick keeps the 1 s delay code affordable
	localparam int MS = 10;
	logic        clk_i;
	logic        rst_i;
	logic        cyc_i;
	logic        stb_i;
	logic        we_i;
	logic        pin_a;
	logic        fault_c;
	logic        reen_c;
	logic [17:0] adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        en_c;
	logic        ss_c;
	logic [7:0]  rd;
	int          error_cnt;
	int          cmp_count;
	int          n;
	int          k;
	int          b;
	int          mdl[int];
	int          dms[4] = '{0, 50, 250, 1000};

	chan_power_seq #(.MS_CYCLES(MS)) u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .chan_a_on_request_i(pin_a),
		.chan_b_on_request_i(1'b0), .fault_a_i(1'b0), .fault_b_i(1'b0),
		.fault_c_i(fault_c), .reenable_a_i(1'b0), .reenable_b_i(1'b0),
		.reenable_c_i(reen_c), .chan_a_enable_o(), .chan_b_enable_o(),
		.chan_c_enable_o(en_c), .soft_start_a_o(), .soft_start_b_o(),
		.soft_start_c_o(ss_c)
	);

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic finish_test;
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Classic single cycle; held until ack is seen, released after it
	task automatic wb(input logic w, input logic [15:0] idx,
			input logic [7:0] wd);
		int t;
		t = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= {idx, 2'b00};
		dat_i <= {24'h000000, wd};
		@(negedge clk_i);
		while (ack_o !== 1'b1 && t < 20) begin
			@(negedge clk_i);
			t++;
		end
		if (t == 20) error_cnt++;
		rd = dat_o[7:0];
		@(posedge clk_i);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
		if (w && mdl.exists(idx)) mdl[idx] = wd;
	endtask

	// Sampled mid-cycle so a one-cycle pulse is never missed
	task automatic wait_for(input int which, input logic lvl);
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (((which == 0) ? ss_c : en_c) !== lvl && n < 20000);
	endtask

	task automatic setpin(input logic v);
		@(posedge clk_i);
		pin_a <= v;
	endtask

	initial begin
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 18'h00000;
		sel_i = 4'hF;
		dat_i = 32'h00000000;
		pin_a = 1'b0;
		fault_c = 1'b0;
		reen_c = 1'b0;
		error_cnt = 0;
		cmp_count = 0;
		void'($urandom(28));
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		for (k = 1; k < 4; k++) mdl[32'hFE78 + k] = 0;
		for (k = 1; k < 4; k++) begin
			wb(1'b0, 16'(32'hFE78 + k), 8'h00);
			chk(rd, mdl[32'hFE78 + k]);
		end
		wb(1'b1, 16'h0100, 8'hFF);
		wb(1'b0, 16'h0100, 8'h00);
		chk(rd, 8'h00);
		wb(1'b1, STATUS_IDX, 8'h00);
		wb(1'b0, STATUS_IDX, 8'h00);
		chk(rd, 8'h3F);
		chk(en_c, 1'b1);
		wb(1'b1, CHB_SET_IDX, 8'($urandom));
		wb(1'b0, CHB_SET_IDX, 8'h00);
		chk(rd, mdl[CHB_SET_IDX]);
		wb(1'b1, CHA_SET_IDX, 8'h10);
		wb(1'b1, CHB_SET_IDX, 8'h20);
		wb(1'b1, CHC_SEQ_IDX, 8'h10);
		wait_for(1, 1'b0);
		chk(n < 10, 1'b1);
		for (k = 0; k < 4; k++) begin
			wb(1'b1, CHC_SEQ_IDX, 8'(8'h10 | (k << 2)));
			setpin(1'b1);
			wait_for(0, 1'b1);
			chk(n >= dms[k] * MS - MS && n <= dms[k] * MS + 10, 1'b1);
			setpin(1'b0);
			wait_for(1, 1'b0);
		end
		wb(1'b1, CHC_SEQ_IDX, 8'h11);
		setpin(1'b1);
		wait_for(0, 1'b1);
		setpin(1'b0);
		wait_for(1, 1'b0);
		chk(n >= 49 * MS && n <= 50 * MS + 10, 1'b1);
		for (b = 0; b < 2; b++) begin
			wb(1'b1, CHC_SEQ_IDX, 8'((b << 7) | 8'h14));
			setpin(1'b1);
			wait_for(0, 1'b1);
			@(posedge clk_i);
			fault_c <= 1'b1;
			wait_for(1, 1'b0);
			@(posedge clk_i);
			fault_c <= 1'b0;
			reen_c <= 1'b1;
			@(posedge clk_i);
			reen_c <= 1'b0;
			wait_for(0, 1'b1);
			if (b == 1) begin
				chk(n >= 49 * MS && n <= 50 * MS + 10, 1'b1);
			end else begin
				chk(n <= 10, 1'b1);
			end
			setpin(1'b0);
			wait_for(1, 1'b0);
		end
		finish_test;
	end

	initial begin
		repeat (40000) @(posedge clk_i);
		error_cnt++;
		finish_test;
	end
endmodule
`default_nettype wire
